// ---- design/lst_pkg.sv ----
package lst_pkg;

  // ****************************************************************
  // Trigger mode encoding
  // ****************************************************************
  localparam logic [2:0] LST_MODE_FREE_RUN   = 3'h0; // Internal timing, all lines
  localparam logic [2:0] LST_MODE_READOUT    = 3'h1; // trigger_readout_mode
  localparam logic [2:0] LST_MODE_FREE_MAX   = 3'h2; // Internal, max line rate
  localparam logic [2:0] LST_MODE_EXPOSURE   = 3'h4; // trigger_exposure_mode
  localparam logic [2:0] LST_MODE_CONTROLLED = 3'h5; // trigger_controlled_exposure_mode
  localparam int         LST_MODE_FRAME_BIT  = 3;    // Adds 8: frame edge gate
  localparam int         LST_MODE_LEVEL_BIT  = 4;    // Adds 16: active-low level gate

  // ****************************************************************
  // Command acknowledge codes
  // ****************************************************************
  localparam logic LST_ACK_OK     = 1'h0;
  localparam logic LST_ACK_NOT_OK = 1'h1;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam int          LST_CLK_MHZ        = 125;
  localparam logic [4:0]  LST_RST_MODE       = 5'h00;
  localparam logic [14:0] LST_RST_DIVIDER    = 15'h0001;
  localparam logic [14:0] LST_RST_LINES      = 15'h0001;
  localparam logic [15:0] LST_RST_EXPOSURE   = 16'h00A2; // 162 us
  localparam logic [15:0] LST_RST_LINE_PER   = 16'h00A2; // Line period in us
  localparam logic [15:0] LST_MIN_EXPOSURE   = 16'h00A2;
  localparam logic [15:0] LST_MAX_EXPOSURE   = 16'h4E20; // 20000 us
  localparam logic [15:0] LST_MIN_LINE_PER   = 16'h00A2; // Fastest line, 6170 Hz
  localparam logic [6:0]  LST_US_CYCLES      = 7'(LST_CLK_MHZ);

  // ****************************************************************
  // Parameter record carried between command port and timing
  // ****************************************************************
  typedef struct packed {
    logic [4:0]  mode;      // Trigger mode plus frame flags
    logic [14:0] divider;   // Trigger divider ratio
    logic [14:0] lines;     // Lines per frame
    logic [15:0] exposure;  // Exposure time in us
    logic [15:0] line_per;  // Internal line period in us
  } lst_cfg_t;

  localparam lst_cfg_t LST_RST_CFG = '{LST_RST_MODE, LST_RST_DIVIDER, LST_RST_LINES,
                                      LST_RST_EXPOSURE, LST_RST_LINE_PER};

  // Set command selector
  typedef enum logic [2:0] {
    LST_SET_MODE, LST_SET_DIVIDER, LST_SET_LINES, LST_SET_EXPOSURE, LST_SET_LINE_PER, LST_SET_BAD
  } lst_sel_t;

endpackage : lst_pkg

// ---- design/lst_timing.sv ----
`timescale 1ns/10ps
// Function
// R1: Primary trigger falling edge starts a line
// R2: Second trigger input also qualifies edges
// R3: Frame trigger falling edge launches frame
// R4: Frame gating combines with any line mode
// R5: Triggers pass through programmable divider
// R6: Mode 0 free-runs at programmed period
// R7: Mode 1 trigger reads out at line clock
// R8: Source keeps trigger period above exposure
// R9: Mode 4 trigger restarts timed exposure
// R10: Mode 4 next trigger reads out line
// R11: Mode 4 only with shutter control
// R12: Mode 5 trigger starts exposure and readout
// R13: Frame gating withholds video until edge
// R14: Host programs lines per frame beforehand
// R15: Colour lines blue, green, red, one apart
// R16: Set commands acknowledged zero or one
// R17: Settings persist in non-volatile store
// R18: Request returns values, not acknowledge
// R19: Mode value selects line trigger mode
// R20: Plus 8 edge frame, plus 16 level
// R21: Divider forwards one per N edges
module lst_timing #(
  parameter bit HAS_SHUTTER = 1'b1      // Variant implements integration control
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              line_trig_a_n,  // Primary line trigger pin
  input  wire logic              line_trig_b_n,  // Secondary line trigger pin
  input  wire logic              frame_trig_n,   // Frame trigger pin
  input  wire logic              cmd_valid,      // Command strobe
  input  wire logic              cmd_is_request, // High for request, low for set
  input  wire lst_pkg::lst_sel_t cmd_sel,        // Parameter selector
  input  wire logic [15:0]       cmd_value,      // Set value
  input  wire logic              nv_valid,       // Restore strobe from storage
  input  wire lst_pkg::lst_cfg_t nv_cfg,         // Record restored at start-up
  output lst_pkg::lst_cfg_t      nv_cfg_out,     // Record to store
  output logic                   nv_write,       // Store strobe
  output logic                   rsp_valid,      // Answer strobe
  output logic                   rsp_is_ack,     // Answer is acknowledge
  output logic [15:0]            rsp_data,       // Ack code or value
  output logic                   exposing,       // Exposure in progress
  output logic                   scan_begin_pulse, // Exposure start
  output logic                   readout_pulse,  // Line readout
  output logic [1:0]             readout_colour, // 0 blue,1 green,2 red
  output logic                   video_valid,    // Line data released
  output logic                   frame_active    // Frame in progress
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] sync1;   // First stage, read only by sync2
  logic [2:0] sync2;   // Second stage
  logic [2:0] sync3;   // Previous value for edge detection

  // Three pins share one generate loop
  for (genvar i = 0; i < 3; i++) begin : g_sync
    wire logic pin = (i == 0) ? line_trig_a_n : (i == 1) ? line_trig_b_n : frame_trig_n;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        sync1[i] <= 1'b1;
        sync2[i] <= 1'b1;
        sync3[i] <= 1'b1;
      end else begin
        sync1[i] <= pin;
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
      end
    end
  end

  wire logic [2:0] fall = sync3 & ~sync2;       // Falling edges
  wire logic line_edge  = fall[0] | fall[1];    // R1 R2
  wire logic frame_edge = fall[2];              // R3

  // ****************************************************************
  // Configuration and command channel
  // ****************************************************************
  lst_pkg::lst_cfg_t cfg;
  lst_pkg::lst_cfg_t next_cfg;
  logic              set_ok;

  wire logic [2:0] mode_low = cmd_value[2:0];
  // Mode 4 refused on variants without shutter control
  wire logic mode_ok = (cmd_value[15:5] == 11'h000) &&
                       (mode_low == lst_pkg::LST_MODE_FREE_RUN || mode_low == lst_pkg::LST_MODE_READOUT ||
                        mode_low == lst_pkg::LST_MODE_FREE_MAX || mode_low == lst_pkg::LST_MODE_CONTROLLED ||
                        (mode_low == lst_pkg::LST_MODE_EXPOSURE && HAS_SHUTTER)) &&
                       !(cmd_value[lst_pkg::LST_MODE_FRAME_BIT] && cmd_value[lst_pkg::LST_MODE_LEVEL_BIT]); // R11 R19 R20
  wire logic cnt_ok  = (cmd_value[15] == 1'b0) && (cmd_value[14:0] != 15'h0000);
  wire logic exp_ok  = (cmd_value >= lst_pkg::LST_MIN_EXPOSURE) && (cmd_value <= lst_pkg::LST_MAX_EXPOSURE);
  wire logic per_ok  = (cmd_value >= lst_pkg::LST_MIN_LINE_PER);

  // Validate set value and form next record
  always_comb begin
    next_cfg = cfg;
    set_ok   = 1'b0;
    case (cmd_sel)
      lst_pkg::LST_SET_MODE: begin
        set_ok = mode_ok;
        if (mode_ok) next_cfg.mode = cmd_value[4:0];
      end
      lst_pkg::LST_SET_DIVIDER: begin
        set_ok = cnt_ok;
        if (cnt_ok) next_cfg.divider = cmd_value[14:0];
      end
      lst_pkg::LST_SET_LINES: begin
        set_ok = cnt_ok;
        if (cnt_ok) next_cfg.lines = cmd_value[14:0];
      end
      lst_pkg::LST_SET_EXPOSURE: begin
        set_ok = exp_ok;
        if (exp_ok) next_cfg.exposure = cmd_value;
      end
      lst_pkg::LST_SET_LINE_PER: begin
        set_ok = per_ok;
        if (per_ok) next_cfg.line_per = cmd_value;
      end
      default: set_ok = 1'b0;  // Unknown selector refused
    endcase
  end

  // Request readback value
  logic [15:0] req_val;
  always_comb begin
    case (cmd_sel)
      lst_pkg::LST_SET_MODE:     req_val = {11'h000, cfg.mode};
      lst_pkg::LST_SET_DIVIDER:  req_val = {1'h0, cfg.divider};
      lst_pkg::LST_SET_LINES:    req_val = {1'h0, cfg.lines};
      lst_pkg::LST_SET_EXPOSURE: req_val = cfg.exposure;
      lst_pkg::LST_SET_LINE_PER: req_val = cfg.line_per;
      default:                   req_val = 16'h0000;
    endcase
  end

  // Apply, answer and store; restore from storage takes precedence
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg        <= lst_pkg::LST_RST_CFG;
      nv_cfg_out <= lst_pkg::LST_RST_CFG;
      nv_write   <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_is_ack <= 1'b0;
      rsp_data   <= 16'h0000;
    end else begin
      nv_write  <= 1'b0;
      rsp_valid <= cmd_valid && !nv_valid;
      if (nv_valid) begin
        cfg <= nv_cfg;                                              // R17
      end else if (cmd_valid && cmd_is_request) begin
        rsp_is_ack <= 1'b0;                                         // R18
        rsp_data   <= req_val;                                      // R18
      end else if (cmd_valid) begin
        rsp_is_ack <= 1'b1;
        rsp_data   <= {15'h0000, set_ok ? lst_pkg::LST_ACK_OK : lst_pkg::LST_ACK_NOT_OK}; // R16
        if (set_ok) begin
          cfg        <= next_cfg;
          nv_cfg_out <= next_cfg;                                   // R17
          nv_write   <= 1'b1;                                       // R17
        end
      end
    end
  end

  // ****************************************************************
  // Trigger divider
  // ****************************************************************
  logic [14:0] div_cnt;
  wire logic   div_last  = (div_cnt + 15'h0001 >= cfg.divider);
  wire logic   trig      = line_edge && div_last;                    // R5 R21

  // Count qualified edges, forward every Nth
  always_ff @(posedge clk) begin
    if (sys_rst) div_cnt <= 15'h0000;
    else if (line_edge) div_cnt <= div_last ? 15'h0000 : div_cnt + 15'h0001; // R21
  end

  // ****************************************************************
  // Microsecond tick and line / exposure timers
  // ****************************************************************
  logic [6:0]  us_cnt;
  wire logic   us_tick = (us_cnt == lst_pkg::LST_US_CYCLES - 7'h01);
  logic [15:0] line_cnt;   // Internal line clock, us
  logic [15:0] exp_cnt;    // Exposure elapsed, us

  wire logic [2:0] mode   = cfg.mode[2:0];
  wire logic m_free       = (mode == lst_pkg::LST_MODE_FREE_RUN) || (mode == lst_pkg::LST_MODE_FREE_MAX);
  wire logic m_readout    = (mode == lst_pkg::LST_MODE_READOUT);
  wire logic m_exposure   = (mode == lst_pkg::LST_MODE_EXPOSURE);
  wire logic m_controlled = (mode == lst_pkg::LST_MODE_CONTROLLED);
  // Max-rate mode runs at the shortest period
  wire logic [15:0] period = (mode == lst_pkg::LST_MODE_FREE_MAX) ? lst_pkg::LST_MIN_LINE_PER : cfg.line_per;
  wire logic line_clk     = us_tick && (line_cnt + 16'h0001 >= period);
  wire logic exp_done     = exposing && us_tick && (exp_cnt + 16'h0001 >= cfg.exposure);
  logic pend_readout;     // Mode 1 trigger waiting for line clock

  // Readout and exposure start decisions per mode
  wire logic do_readout = (m_free && line_clk) ||                        // R6
                          (m_readout && line_clk && (pend_readout || trig)) || // R7
                          (m_exposure && trig) ||                        // R10
                          (m_controlled && trig);                        // R12
  wire logic do_start   = ((m_free || m_readout) && line_clk) ||         // R6 R7
                          (m_exposure && trig) ||                        // R9
                          (m_controlled && trig);                        // R12

  // Free-running microsecond prescaler
  always_ff @(posedge clk) begin
    if (sys_rst) us_cnt <= 7'h00;
    else us_cnt <= us_tick ? 7'h00 : us_cnt + 7'h01;
  end

  // Internal line clock, period in us
  always_ff @(posedge clk) begin
    if (sys_rst) line_cnt <= 16'h0000;
    else if (line_clk) line_cnt <= 16'h0000;
    else if (us_tick) line_cnt <= line_cnt + 16'h0001;
  end

  // Mode 1 trigger is held until the next line clock
  always_ff @(posedge clk) begin
    if (sys_rst) pend_readout <= 1'b0;
    else if (!m_readout || line_clk) pend_readout <= 1'b0;   // R7
    else if (trig) pend_readout <= 1'b1;                     // R7
  end

  // Exposure window; a start aborts any exposure in progress
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      exposing <= 1'b0;
      exp_cnt  <= 16'h0000;
    end else if (do_start) begin
      exposing <= 1'b1;                                        // R9
      exp_cnt  <= 16'h0000;
    end else if (m_controlled) begin
      exposing <= exposing;                                    // R12
    end else if (exp_done) begin
      exposing <= 1'b0;
    end else if (exposing && us_tick) begin
      exp_cnt  <= exp_cnt + 16'h0001;
    end
  end

  // ****************************************************************
  // Frame gating
  // ****************************************************************
  logic [14:0] frame_left;
  wire logic   gate_edge  = cfg.mode[lst_pkg::LST_MODE_FRAME_BIT];
  wire logic   gate_level = cfg.mode[lst_pkg::LST_MODE_LEVEL_BIT];
  wire logic   gate_open  = gate_edge ? frame_active :
                            gate_level ? !sync2[2] : 1'b1;     // R4 R13 R20

  // Lines per frame count ends an edge-started frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_active <= 1'b0;
      frame_left   <= 15'h0000;
    end else if (!gate_edge) begin
      frame_active <= 1'b0;
    end else if (frame_edge && !frame_active) begin
      frame_active <= 1'b1;                                    // R3
      frame_left   <= cfg.lines;                               // R14
    end else if (frame_active && do_readout) begin
      frame_left   <= frame_left - 15'h0001;
      if (frame_left == 15'h0001) frame_active <= 1'b0;
    end
  end

  // ****************************************************************
  // Line outputs and colour sequence
  // ****************************************************************
  // Colour index steps blue, green, red each line
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scan_begin_pulse <= 1'b0;
      readout_pulse    <= 1'b0;
      video_valid      <= 1'b0;
      readout_colour   <= 2'h0;
    end else begin
      scan_begin_pulse <= do_start;
      readout_pulse    <= do_readout;
      video_valid      <= do_readout && gate_open;             // R13
      if (do_readout) readout_colour <= (readout_colour == 2'h2) ? 2'h0 : readout_colour + 2'h1; // R15
    end
  end

endmodule : lst_timing

// ---- verification/lst_trig_src.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Encoder model: drives the three sync pins
// ****************************************************************
module lst_trig_src #(
  parameter int LOW_CYCLES = 4 // Low width of each trigger
) (
  input  wire logic       clk,
  input  wire logic [2:0] fire,  // One request per pin: line A, line B, frame
  output logic      [2:0] pin_n  // Idle high, as a pulled-up TTL line rests
);
  logic [3:0] left [3]; // Low cycles still to hold per pin

  initial begin
    pin_n = 3'h7;
    left  = '{4'h0, 4'h0, 4'h0};
  end

  // A request makes one falling edge, then the pin returns high
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (fire[i]) begin
        left[i]  <= 4'(LOW_CYCLES);
        pin_n[i] <= 1'b0;
      end else if (left[i] > 4'h1) begin
        left[i] <= left[i] - 4'h1;
      end else begin
        left[i]  <= 4'h0;
        pin_n[i] <= 1'b1;
      end
    end
  end
endmodule : lst_trig_src

// ---- verification/lst_timing_chk.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Port checker for the trigger timing block
// ****************************************************************
module lst_timing_chk (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              cmd_valid,
  input wire logic              cmd_is_request,
  input wire logic              nv_valid,
  input wire lst_pkg::lst_cfg_t nv_cfg_out,
  input wire logic              nv_write,
  input wire logic              rsp_valid,
  input wire logic              rsp_is_ack,
  input wire logic [15:0]       rsp_data,
  input wire logic              exposing,
  input wire logic              scan_begin_pulse,
  input wire logic              readout_pulse,
  input wire logic [1:0]        readout_colour,
  input wire logic              video_valid,
  input wire logic              frame_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_ack_latency: assert property (cmd_valid && !nv_valid |=> rsp_valid)
    else $error("command not answered next cycle");
  a_rsp_cause: assert property (rsp_valid |-> $past(cmd_valid) && !$past(nv_valid))
    else $error("answer without command");
  a_rsp_kind: assert property (rsp_valid |-> rsp_is_ack == !$past(cmd_is_request))
    else $error("answer kind wrong");
  a_ack_code: assert property (rsp_valid && rsp_is_ack |-> rsp_data[15:1] == 15'h0000)
    else $error("ack code not 0 or 1");
  a_store_only_ok: assert property (nv_write |-> rsp_valid && rsp_is_ack && rsp_data == 16'h0000)
    else $error("store without accepted set");
  a_ok_stores: assert property (rsp_valid && rsp_is_ack && rsp_data == 16'h0000 |-> nv_write)
    else $error("accepted set not stored");
  a_pulse_pair: assert property (readout_pulse && nv_cfg_out.mode[2:0] inside {3'h4, 3'h5}
    |-> scan_begin_pulse)
    else $error("readout without new exposure");
  a_colour_order: assert property ($changed(readout_colour) |-> readout_colour ==
    ($past(readout_colour) == 2'h2 ? 2'h0 : $past(readout_colour) + 2'h1))
    else $error("colour order wrong");
  a_video_gated: assert property (video_valid && nv_cfg_out.mode[3] |-> $past(frame_active))
    else $error("video outside frame");
  a_begin_exposes: assert property (scan_begin_pulse |=> exposing)
    else $error("scan begin without exposure");
endmodule : lst_timing_chk

// ---- verification/tb_line_scan_trigger_timing.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Testbench top
// ****************************************************************
module tb_line_scan_trigger_timing;
  logic              clk, sys_rst, cmd_valid, cmd_is_request, nv_valid, nv_write;
  logic              rsp_valid, rsp_is_ack, exposing, scan_begin_pulse, readout_pulse;
  logic              video_valid, frame_active;
  lst_pkg::lst_sel_t cmd_sel;
  logic [15:0]       cmd_value, rsp_data, rnd;
  lst_pkg::lst_cfg_t nv_cfg, nv_cfg_out;
  logic [1:0]        readout_colour;
  logic [2:0]        fire, pin_n;
  logic [16:0]       exp_q [$];   // Expected {is_ack, data}, oldest first
  int                errors, tests_run, n_ro, n_sb, n_vv;
  logic [4:0]        modes [11] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h09, 5'h11, 5'h03, 5'h06, 5'h07, 5'h19};
  localparam logic [16:0] ACK_OK  = {1'b1, 15'h0000, lst_pkg::LST_ACK_OK};
  localparam logic [16:0] ACK_NOK = {1'b1, 15'h0000, lst_pkg::LST_ACK_NOT_OK};

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  lst_timing dut (.line_trig_a_n(pin_n[0]), .line_trig_b_n(pin_n[1]), .frame_trig_n(pin_n[2]), .*);
  lst_trig_src u_src (.clk(clk), .fire(fire), .pin_n(pin_n));

  // Single compare point; every result is counted
  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  // One command, one cycle wide; a gap cycle keeps strobes apart
  task automatic send(input logic req, input lst_pkg::lst_sel_t sel, input logic [15:0] val,
                      input logic [16:0] want);
    @(posedge clk);
    cmd_valid      <= 1'b1;
    cmd_is_request <= req;
    cmd_sel        <= sel;
    cmd_value      <= val;
    exp_q.push_back(want);
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : send

  // One falling edge on a pin, then a quiet gap
  task automatic trig(input int pin, input int gap);
    @(posedge clk);
    fire[pin] <= 1'b1;
    @(posedge clk);
    fire[pin] <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask : trig

  task automatic results;
    check(17'(exp_q.size()), 17'h00000);
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Output watcher: answers against notes, pulse counts
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() > 0) begin
        check({rsp_is_ack, rsp_data}, exp_q.pop_front());
      end else begin
        errors++;
        $display("[FAIL] %0t unexpected answer", $time);
      end
    end
    n_ro += int'(readout_pulse === 1'b1);
    n_sb += int'(scan_begin_pulse === 1'b1);
    n_vv += int'(video_valid === 1'b1);
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("[FAIL] %0t run limit hit", $time);
    results();
  end

  initial begin
    rnd            = 16'($urandom(32'h9FE2A738));
    {sys_rst, cmd_valid, cmd_is_request, nv_valid, fire, cmd_value} = {4'hA, 3'h0, 16'h0000};
    cmd_sel        = lst_pkg::LST_SET_MODE;
    nv_cfg         = lst_pkg::LST_RST_CFG;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    send(1'b1, lst_pkg::LST_SET_EXPOSURE, 16'h0000, {1'b0, lst_pkg::LST_RST_EXPOSURE});
    foreach (modes[i]) send(1'b0, lst_pkg::LST_SET_MODE, 16'(modes[i]), i < 7 ? ACK_OK : ACK_NOK);
    send(1'b1, lst_pkg::LST_SET_MODE, 16'h0000, {1'b0, 16'h0011});
    send(1'b0, lst_pkg::LST_SET_DIVIDER, 16'h0000, ACK_NOK);
    send(1'b0, lst_pkg::LST_SET_LINES, 16'h0000, ACK_NOK);
    send(1'b0, lst_pkg::LST_SET_EXPOSURE, 16'h00A1, ACK_NOK);
    send(1'b0, lst_pkg::LST_SET_EXPOSURE, 16'h4E21, ACK_NOK);
    send(1'b0, lst_pkg::LST_SET_EXPOSURE, 16'h4E20, ACK_OK);
    send(1'b0, lst_pkg::LST_SET_LINE_PER, 16'h00A1, ACK_NOK);
    send(1'b0, lst_pkg::LST_SET_BAD, 16'h0001, ACK_NOK);
    send(1'b0, lst_pkg::LST_SET_EXPOSURE, 16'h00A2, ACK_OK);
    // Random ratio round trip, then a restore that must stay silent
    rnd = 16'($urandom_range(32767, 1));
    send(1'b0, lst_pkg::LST_SET_DIVIDER, rnd, ACK_OK);
    send(1'b1, lst_pkg::LST_SET_DIVIDER, 16'h0000, {1'b0, rnd});
    @(posedge clk);
    nv_cfg.divider <= 15'($urandom_range(32767, 1));
    nv_valid       <= 1'b1;
    @(posedge clk);
    nv_valid <= 1'b0;
    send(1'b1, lst_pkg::LST_SET_DIVIDER, 16'h0000, {1'b0, 1'b0, nv_cfg.divider});
    // Restart mode: each edge reads out and restarts, spaced past exposure
    send(1'b0, lst_pkg::LST_SET_DIVIDER, 16'h0001, ACK_OK);
    send(1'b0, lst_pkg::LST_SET_MODE, 16'h0004, ACK_OK);
    #1 {n_ro, n_sb} = '0;
    repeat (3) trig(0, 20400);
    check({n_ro[7:0], n_sb[8:0]}, {8'd3, 9'd3});
    // Start-of-scan mode on the second input, ratio two
    send(1'b0, lst_pkg::LST_SET_DIVIDER, 16'h0002, ACK_OK);
    send(1'b0, lst_pkg::LST_SET_MODE, 16'h0005, ACK_OK);
    #1 {n_ro, n_sb} = '0;
    repeat (4) trig(1, 40);
    check({n_ro[7:0], n_sb[8:0]}, {8'd2, 9'd2});
    // Frame gate: no video before the frame edge, then two lines
    send(1'b0, lst_pkg::LST_SET_DIVIDER, 16'h0001, ACK_OK);
    send(1'b0, lst_pkg::LST_SET_LINES, 16'h0002, ACK_OK);
    send(1'b0, lst_pkg::LST_SET_MODE, 16'h000D, ACK_OK);
    #1 n_vv = 0;
    repeat (2) trig(0, 40);
    check(17'(n_vv), 17'h00000);
    trig(2, 20);
    repeat (3) trig(0, 40);
    check(17'(n_vv), 17'h00002);
    check(17'(frame_active), 17'h00000);
    results();
  end
endmodule : tb_line_scan_trigger_timing

bind lst_timing lst_timing_chk u_chk (.*);
